// >>> hdl/clock_watchdog_reset_unit.sv
// Clock source switch, peripheral dividers, watchdog, calibration and trim
`timescale 1ns/1ps
module clock_watchdog_reset_unit
  import clock_watchdog_pkg::*;
#(
  parameter int NUM_DIV   = 16,
  parameter int NUM_FIXED = 12,
  parameter int NUM_PLB   = 4,
  parameter int DIV_W     = 16
)
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst_b,
  input  wire logic                            ce,
  input  wire logic                            main_osc_in,
  input  wire logic                            lowpower_osc_in,
  input  wire logic                            crystal_osc_in,
  input  wire logic                            ext_clk_in,
  input  wire logic                            external_reset_pin_b,
  input  wire clock_watchdog_pkg::src_sel_t    clk_sel,
  input  wire logic                            lf_sel,
  input  wire logic                            deep_sleep,
  input  wire logic                            crystal_enable,
  input  wire clock_watchdog_pkg::trim_req_t   trim_req,
  input  wire logic [TRIM_W-1:0]               nvm_trim,
  input  wire logic                            nvm_trim_valid,
  input  wire logic [NUM_DIV-1:0][DIV_W-1:0]   div_ratio,
  input  wire clock_watchdog_pkg::wdt_cfg_t    wdt_cfg,
  input  wire logic                            wdt_service,
  input  wire logic                            wdt_irq_clr,
  input  wire clock_watchdog_pkg::cal_req_t    cal_req,
  input  wire logic                            sw_reset_req,
  input  wire clock_watchdog_pkg::cause_t      cause_clr,
  output logic                                 root_fast_clock,
  output logic                                 switch_busy,
  output logic [NUM_FIXED-1:0]                 fixed_clk_en,
  output logic [NUM_PLB-1:0]                   plb_clk_en,
  output logic                                 main_osc_en,
  output logic                                 crystal_osc_en,
  output logic                                 lowpower_osc_en,
  output logic [FREQ_W-1:0]                    main_osc_freq_mhz,
  output logic [TRIM_W-1:0]                    main_osc_trim,
  output logic                                 wdt_irq,
  output logic [CAL_W-1:0]                     cal_count,
  output logic                                 cal_done,
  output logic                                 core_rst_b,
  output clock_watchdog_pkg::cause_t           reset_cause
);
  import clock_watchdog_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NUM_FIXED + NUM_PLB != NUM_DIV)
  begin : g_bad_split
    $error("Divider groups must add up to the divider count");
  end
  if (NUM_FIXED < 2 || NUM_PLB < 1 || DIV_W < 1)
  begin : g_bad_size
    $error("Divider configuration too small");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_SRC-1:0]              sync1;
    logic [NUM_SRC-1:0]              sync2;
    logic [NUM_SRC-1:0]              prev;
    src_sel_t                        cur_sel;
    src_sel_t                        new_sel;
    switch_state_t                   sw_state;
    logic                            gate;
    logic                            root;
    logic                            root_prev;
    logic [NUM_DIV-1:0][DIV_W-1:0]   div_cnt;
    logic [NUM_DIV-1:0]              div_pulse;
    logic [NUM_DIV-1:0]              div_dly;
    logic [WDT_W-1:0]                wdt_cnt;
    logic                            wdt_irq;
    logic                            wdt_rst;
    cal_state_t                      cal_state;
    logic [CAL_W-1:0]                cal_win;
    logic [CAL_W-1:0]                cal_acc;
    logic [CAL_W-1:0]                cal_result;
    logic                            cal_done;
    logic [FREQ_W-1:0]               freq;
    logic [TRIM_W-1:0]               trim;
    logic                            main_en;
    logic                            crystal_en;
  } state_t;

  state_t             s_q;
  state_t             s_d;
  logic [NUM_SRC-1:0] raw_src;
  logic [NUM_SRC-1:0] src_rise;
  logic               root_tick;
  logic               lf_tick;
  logic               wdt_expire;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic rising(input logic now_lvl, input logic old_lvl);
    rising = now_lvl & ~old_lvl;
  endfunction

  function automatic logic [FREQ_W-1:0] clamp_freq(input logic [FREQ_W-1:0] f);
    if (f < FREQ_MIN_MHZ)
    begin
      clamp_freq = FREQ_MIN_MHZ;
    end
    else if (f > FREQ_MAX_MHZ)
    begin
      clamp_freq = FREQ_MAX_MHZ;
    end
    else
    begin
      clamp_freq = f;
    end
  endfunction

  // ****************************************************************
  // Source edges
  // ****************************************************************
  always_comb
  begin
    raw_src               = '0;
    raw_src[SRC_MAIN]     = main_osc_in;
    raw_src[SRC_LOWPOWER] = lowpower_osc_in;
    raw_src[SRC_CRYSTAL]  = crystal_osc_in;
    raw_src[SRC_EXTERNAL] = ext_clk_in;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      src_rise[i] = rising(s_q.sync2[i], s_q.prev[i]);
    end
  end

  assign root_tick  = rising(s_q.root, s_q.root_prev);
  assign lf_tick    = (lf_sel == LF_SEL_CRYSTAL) ? src_rise[SRC_CRYSTAL]
                                                 : src_rise[SRC_LOWPOWER];
  assign wdt_expire = wdt_cfg.enable && !wdt_service && lf_tick
                      && (s_q.wdt_cnt >= wdt_cfg.timeout);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = raw_src;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;

    // Source changeover
    case (s_q.sw_state)
      SW_RUN:
      begin
        if (clk_sel != s_q.cur_sel)
        begin
          s_d.new_sel  = clk_sel;
          s_d.sw_state = SW_DRAIN_OLD;
        end
      end
      SW_DRAIN_OLD:
      begin
        if (!s_q.sync2[s_q.cur_sel])
        begin
          s_d.gate     = 1'b0;
          s_d.sw_state = SW_ARM_NEW;
        end
      end
      SW_ARM_NEW:
      begin
        if (!s_q.sync2[s_q.new_sel])
        begin
          s_d.cur_sel  = s_q.new_sel;
          s_d.gate     = 1'b1;
          s_d.sw_state = SW_RUN;
        end
      end
      default:
      begin
        s_d.sw_state = SW_RUN;
      end
    endcase
    s_d.root      = s_d.gate & s_q.sync2[s_d.cur_sel];
    s_d.root_prev = s_q.root;

    // Peripheral dividers
    for (int i = 0; i < NUM_DIV; i++)
    begin
      s_d.div_pulse[i] = 1'b0;
      if (root_tick)
      begin
        if (s_q.div_cnt[i] >= div_ratio[i])
        begin
          s_d.div_cnt[i]   = '0;
          s_d.div_pulse[i] = 1'b1;
        end
        else
        begin
          s_d.div_cnt[i] = s_q.div_cnt[i] + DIV_W'(1);
        end
      end
    end
    s_d.div_dly = s_q.div_pulse;

    // Watchdog
    s_d.wdt_rst = 1'b0;
    if (wdt_irq_clr)
    begin
      s_d.wdt_irq = 1'b0;
    end
    if (!wdt_cfg.enable || wdt_service)
    begin
      s_d.wdt_cnt = '0;
    end
    else if (lf_tick)
    begin
      if (wdt_expire)
      begin
        s_d.wdt_cnt = '0;
        if (wdt_cfg.reset_mode)
        begin
          s_d.wdt_rst = 1'b1;
        end
        else
        begin
          s_d.wdt_irq = 1'b1;
        end
      end
      else
      begin
        s_d.wdt_cnt = s_q.wdt_cnt + WDT_W'(1);
      end
    end

    // Low-frequency clock calibration (low-power or crystal, per lf_sel)
    case (s_q.cal_state)
      CAL_IDLE:
      begin
        if (cal_req.start)
        begin
          s_d.cal_win   = '0;
          s_d.cal_acc   = '0;
          s_d.cal_done  = 1'b0;
          s_d.cal_state = CAL_RUN;
        end
      end
      CAL_RUN:
      begin
        if (src_rise[SRC_MAIN])
        begin
          s_d.cal_acc = s_q.cal_acc + CAL_W'(1);
        end
        if (lf_tick)
        begin
          s_d.cal_win = s_q.cal_win + CAL_W'(1);
          if (s_d.cal_win >= cal_req.window)
          begin
            s_d.cal_result = s_d.cal_acc;
            s_d.cal_done   = 1'b1;
            s_d.cal_state  = CAL_IDLE;
          end
        end
      end
      default:
      begin
        s_d.cal_state = CAL_IDLE;
      end
    endcase

    // Main oscillator setting and trim
    if (trim_req.wr)
    begin
      s_d.freq = clamp_freq(trim_req.freq_mhz);
      s_d.trim = trim_req.trim;
    end
    else if (nvm_trim_valid)
    begin
      s_d.trim = nvm_trim;
    end

    // Oscillator enables
    s_d.main_en    = ~deep_sleep;
    s_d.crystal_en = crystal_enable;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      s_q         <= '0;
      s_q.gate    <= 1'b1;
      s_q.cur_sel <= SRC_MAIN;
      s_q.new_sel <= SRC_MAIN;
      s_q.freq    <= FREQ_RESET_MHZ;
      s_q.trim    <= TRIM_RESET;
      s_q.main_en <= 1'b1;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Reset sequencing
  // ****************************************************************
  reset_control u_reset_control (
    .sys_clk              (sys_clk),
    .rst_b                (rst_b),
    .ce                   (ce),
    .external_reset_pin_b (external_reset_pin_b),
    .sw_reset_req         (sw_reset_req),
    .wdt_reset_req        (s_q.wdt_rst),
    .cause_clr            (cause_clr),
    .core_rst_b           (core_rst_b),
    .reset_cause          (reset_cause)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign root_fast_clock   = s_q.root;
  assign switch_busy       = (s_q.sw_state != SW_RUN);
  assign fixed_clk_en      = {s_q.div_dly[NUM_FIXED-1:ANALOG_DIV+1],
                              s_q.div_pulse[ANALOG_DIV]};
  assign plb_clk_en        = s_q.div_dly[NUM_DIV-1:NUM_FIXED];
  assign main_osc_en       = s_q.main_en;
  assign crystal_osc_en    = s_q.crystal_en;
  assign lowpower_osc_en   = 1'b1;
  assign main_osc_freq_mhz = s_q.freq;
  assign main_osc_trim     = s_q.trim;
  assign wdt_irq           = s_q.wdt_irq;
  assign cal_count         = s_q.cal_result;
  assign cal_done          = s_q.cal_done;

endmodule // clock_watchdog_reset_unit

// >>> hdl/clock_watchdog_pkg.sv
// Constants, types and carriers shared by the clock, watchdog and reset unit
// ****************************************************************************
// ****************************************************************************
package clock_watchdog_pkg;

  localparam int NUM_SRC = 4;

  typedef logic [1:0] src_sel_t;

  localparam src_sel_t SRC_MAIN     = 2'h0;
  localparam src_sel_t SRC_LOWPOWER = 2'h1;
  localparam src_sel_t SRC_CRYSTAL  = 2'h2;
  localparam src_sel_t SRC_EXTERNAL = 2'h3;

  localparam logic LF_SEL_LOWPOWER = 1'b0;
  localparam logic LF_SEL_CRYSTAL  = 1'b1;

  localparam int FREQ_W = 6;
  localparam int TRIM_W = 8;
  localparam int WDT_W  = 16;
  localparam int CAL_W  = 16;

  localparam logic [FREQ_W-1:0] FREQ_RESET_MHZ = 6'h18;
  localparam logic [FREQ_W-1:0] FREQ_MIN_MHZ   = 6'h03;
  localparam logic [FREQ_W-1:0] FREQ_MAX_MHZ   = 6'h30;
  localparam logic [TRIM_W-1:0] TRIM_RESET     = 8'h00;

  localparam int ANALOG_DIV = 0;

  typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_ARM_NEW} switch_state_t;
  typedef enum logic       {CAL_IDLE, CAL_RUN} cal_state_t;

  typedef struct packed {
    logic              enable;
    logic              reset_mode;
    logic [WDT_W-1:0]  timeout;
  } wdt_cfg_t;

  typedef struct packed {
    logic              wr;
    logic [FREQ_W-1:0] freq_mhz;
    logic [TRIM_W-1:0] trim;
  } trim_req_t;

  typedef struct packed {
    logic              start;
    logic [CAL_W-1:0]  window;
  } cal_req_t;

  typedef struct packed {
    logic external;
    logic software;
    logic watchdog;
  } cause_t;

endpackage

// >>> hdl/reset_control.sv
// Reset sequencing and sticky reset cause record
`timescale 1ns/1ps
module reset_control
  import clock_watchdog_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  input  wire logic                      external_reset_pin_b,
  input  wire logic                      sw_reset_req,
  input  wire logic                      wdt_reset_req,
  input  wire clock_watchdog_pkg::cause_t cause_clr,
  output logic                           core_rst_b,
  output clock_watchdog_pkg::cause_t     reset_cause
);
  import clock_watchdog_pkg::*;

  typedef struct packed {
    logic   pin_s1;
    logic   pin_s2;
    logic   req;
    cause_t cause;
  } rc_state_t;

  rc_state_t  r_q;
  rc_state_t  r_d;
  logic [1:0] rel_q;
  logic       chain_rst_b;

  // ****************************************************************
  // Request and cause logic
  // ****************************************************************
  always_comb
  begin
    r_d        = r_q;
    r_d.pin_s1 = ~external_reset_pin_b;
    r_d.pin_s2 = r_q.pin_s1;
    if (sw_reset_req || wdt_reset_req)
    begin
      r_d.req = 1'b1;
    end
    else if (!core_rst_b)
    begin
      r_d.req = 1'b0;
    end
    // Set wins over clear
    if (cause_clr.external) r_d.cause.external = 1'b0;
    if (cause_clr.software) r_d.cause.software = 1'b0;
    if (cause_clr.watchdog) r_d.cause.watchdog = 1'b0;
    if (r_q.pin_s2) r_d.cause.external = 1'b1;
    if (sw_reset_req) r_d.cause.software = 1'b1;
    if (wdt_reset_req) r_d.cause.watchdog = 1'b1;
  end

  // Only power-on reset or cause_clr clears the record
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_q <= '0;
    end
    else if (ce)
    begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // Async assert, sync release
  // ****************************************************************
  assign chain_rst_b = rst_b & external_reset_pin_b & ~r_q.req;

  always_ff @(posedge sys_clk or negedge chain_rst_b)
  begin
    if (!chain_rst_b)
    begin
      rel_q <= 2'h0;
    end
    else if (ce)
    begin
      rel_q <= {rel_q[0], 1'b1};
    end
  end

  assign core_rst_b  = rel_q[1];
  assign reset_cause = r_q.cause;

endmodule // reset_control

// >>> sim/clock_watchdog_checker.sv
// Port-level assertions for the clock, watchdog and reset unit
`timescale 1ns/1ps
module clock_watchdog_checker
  import clock_watchdog_pkg::*;
#(
  parameter int NUM_DIV   = 16,
  parameter int NUM_FIXED = 12,
  parameter int DIV_W     = 16
)
(
  input wire logic                          sys_clk,
  input wire logic                          rst_b,
  input wire logic                          external_reset_pin_b,
  input wire logic                          crystal_enable,
  input wire clock_watchdog_pkg::trim_req_t trim_req,
  input wire logic [NUM_DIV-1:0][DIV_W-1:0] div_ratio,
  input wire clock_watchdog_pkg::wdt_cfg_t  wdt_cfg,
  input wire logic                          sw_reset_req,
  input wire clock_watchdog_pkg::cause_t    cause_clr,
  input wire logic                          root_fast_clock,
  input wire logic                          switch_busy,
  input wire logic [NUM_FIXED-1:0]          fixed_clk_en,
  input wire logic                          crystal_osc_en,
  input wire logic [FREQ_W-1:0]             main_osc_freq_mhz,
  input wire logic [TRIM_W-1:0]             main_osc_trim,
  input wire logic                          wdt_irq,
  input wire logic                          core_rst_b,
  input wire clock_watchdog_pkg::cause_t    reset_cause
);
  import clock_watchdog_pkg::*;

  // ********
  // Checks
  // ********
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Old source may begin a high phase in the first drain cycle
  property p_no_runt;
    switch_busy && $past(switch_busy) && $past(switch_busy, 2) |-> !$rose(root_fast_clock);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("root rose mid switch");
  property p_lead;
    fixed_clk_en[0] && core_rst_b && div_ratio[0] == div_ratio[1]
      |=> fixed_clk_en[1] || !core_rst_b;
  endproperty
  a_lead: assert property (p_lead) else $error("analog pulse not leading");
  property p_pulse; fixed_clk_en[0] && div_ratio[0] != '0 |=> !fixed_clk_en[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("divider pulse too long");
  property p_trim; trim_req.wr && core_rst_b |=> main_osc_trim == $past(trim_req.trim); endproperty
  a_trim: assert property (p_trim) else $error("trim not written");
  property p_clamp;
    trim_req.wr && core_rst_b && trim_req.freq_mhz > FREQ_MAX_MHZ
      |=> main_osc_freq_mhz == FREQ_MAX_MHZ;
  endproperty
  a_clamp: assert property (p_clamp) else $error("frequency not clamped");
  property p_xtal; core_rst_b && $past(core_rst_b) |-> crystal_osc_en == $past(crystal_enable);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
  property p_sw; sw_reset_req && core_rst_b |-> ##[1:3] !core_rst_b; endproperty
  a_sw: assert property (p_sw) else $error("software reset missing");
  property p_ext; !external_reset_pin_b |-> !core_rst_b; endproperty
  a_ext: assert property (p_ext) else $error("pin reset missing");
  property p_rel; $rose(core_rst_b) |-> $past(rst_b) && $past(external_reset_pin_b); endproperty
  a_rel: assert property (p_rel) else $error("reset released early");
  property p_sticky; !(|($past(reset_cause) & ~reset_cause & ~$past(cause_clr))); endproperty
  a_sticky: assert property (p_sticky) else $error("reset cause lost");
  property p_irq;
    $rose(wdt_irq) |-> $past(wdt_cfg.enable) && !$past(wdt_cfg.reset_mode);
  endproperty
  a_irq: assert property (p_irq) else $error("spurious watchdog irq");
  c_switch: cover property (switch_busy ##1 !switch_busy);
  c_irq: cover property ($rose(wdt_irq));
  c_wdt_rst: cover property ($rose(reset_cause.watchdog));
endmodule // clock_watchdog_checker

bind clock_watchdog_reset_unit clock_watchdog_checker
  #(.NUM_DIV(NUM_DIV), .NUM_FIXED(NUM_FIXED), .DIV_W(DIV_W)) i_checker (
  .sys_clk, .rst_b, .external_reset_pin_b, .crystal_enable, .trim_req, .div_ratio,
  .wdt_cfg, .sw_reset_req, .cause_clr, .root_fast_clock, .switch_busy, .fixed_clk_en,
  .crystal_osc_en, .main_osc_freq_mhz, .main_osc_trim, .wdt_irq, .core_rst_b, .reset_cause);

// >>> sim/clock_watchdog_reset_unit_bench.sv
// Self-checking bench for the clock, watchdog and reset unit
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
`define WAIT_FOR(cond, lim) \
  begin n = 0; while (!(cond) && n < (lim)) begin tick(1); n++; end end
module clock_watchdog_reset_unit_bench;
  import clock_watchdog_pkg::*;
  // ********
  // Stimulus
  // ********
  localparam int RATIO = 3;
  localparam int P_MAIN = 4;
  localparam int P_LOW = 40;
  localparam int P_XTAL = 60;
  localparam int P_EXT = 8;
  localparam int TMO = 3;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              ce = 1'b1;
  logic              main_osc_in = 1'b0;
  logic              lowpower_osc_in = 1'b0;
  logic              crystal_osc_in = 1'b0;
  logic              ext_clk_in = 1'b0;
  logic              external_reset_pin_b = 1'b1;
  src_sel_t          clk_sel = SRC_MAIN;
  logic              lf_sel = LF_SEL_LOWPOWER;
  logic              deep_sleep = 1'b0;
  logic              crystal_enable = 1'b1;
  trim_req_t         trim_req = '0;
  logic [TRIM_W-1:0] nvm_trim = '0;
  logic              nvm_trim_valid = 1'b0;
  logic [15:0][15:0] div_ratio = {16{16'(RATIO)}};
  wdt_cfg_t          wdt_cfg = '0;
  logic              wdt_service = 1'b0;
  logic              wdt_irq_clr = 1'b0;
  cal_req_t          cal_req = '0;
  logic              sw_reset_req = 1'b0;
  cause_t            cause_clr = '0;
  logic              root_fast_clock, switch_busy, main_osc_en, crystal_osc_en;
  logic              lowpower_osc_en, wdt_irq, cal_done, core_rst_b;
  logic [11:0]       fixed_clk_en;
  logic [3:0]        plb_clk_en;
  logic [FREQ_W-1:0] main_osc_freq_mhz;
  logic [TRIM_W-1:0] main_osc_trim;
  logic [CAL_W-1:0]  cal_count;
  cause_t            reset_cause;
  int                n_fail = 0;
  int                compares = 0;
  int                cyc = 0;
  int                n;

  clock_watchdog_reset_unit i_dut (
    .sys_clk, .rst_b, .ce, .main_osc_in, .lowpower_osc_in, .crystal_osc_in, .ext_clk_in,
    .external_reset_pin_b, .clk_sel, .lf_sel, .deep_sleep, .crystal_enable, .trim_req,
    .nvm_trim, .nvm_trim_valid, .div_ratio, .wdt_cfg, .wdt_service, .wdt_irq_clr, .cal_req,
    .sw_reset_req, .cause_clr, .root_fast_clock, .switch_busy, .fixed_clk_en, .plb_clk_en,
    .main_osc_en, .crystal_osc_en, .lowpower_osc_en, .main_osc_freq_mhz, .main_osc_trim,
    .wdt_irq, .cal_count, .cal_done, .core_rst_b, .reset_cause);

  always #50 sys_clk = ~sys_clk;

  // Free-running oscillator models
  always @(negedge sys_clk)
  begin
    cyc <= cyc + 1;
    main_osc_in <= (cyc % P_MAIN) < P_MAIN / 2;
    lowpower_osc_in <= (cyc % P_LOW) < P_LOW / 2;
    crystal_osc_in <= (cyc % P_XTAL) < P_XTAL / 2;
    ext_clk_in <= (cyc % P_EXT) < P_EXT / 2;
  end

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    rst_b = 1'b0;
    tick(4);
    `CHK(core_rst_b, 1'b0)
    `CHK(reset_cause, 3'h0)
    `CHK(main_osc_freq_mhz, FREQ_RESET_MHZ)
    `CHK(main_osc_trim, TRIM_RESET)
    `CHK({main_osc_en, lowpower_osc_en}, 2'h3)
    rst_b = 1'b1;
    tick(1);
    `CHK(core_rst_b, 1'b0)
    tick(1);
    `CHK(core_rst_b, 1'b1)
    $display("reset test done");
  endtask

  task automatic t_trim();
    logic [FREQ_W-1:0] fin [4];
    logic [FREQ_W-1:0] fexp [4];
    fin = '{6'h31, 6'h02, 6'h30, 6'h18};
    fexp = '{FREQ_MAX_MHZ, FREQ_MIN_MHZ, FREQ_MAX_MHZ, FREQ_RESET_MHZ};
    nvm_trim = 8'h5a;
    pulse(nvm_trim_valid);
    `CHK(main_osc_trim, 8'h5a)
    for (int i = 0; i < 4; i++)
    begin
      trim_req = '{1'b1, fin[i], 8'h20 + 8'(i)};
      tick(1);
      trim_req.wr = 1'b0;
      tick(1);
      `CHK(main_osc_freq_mhz, fexp[i])
      `CHK(main_osc_trim, 8'h20 + 8'(i))
    end
    deep_sleep = 1'b1;
    tick(2);
    `CHK({main_osc_en, crystal_osc_en}, 2'h1)
    deep_sleep = 1'b0;
    tick(2);
    `CHK(main_osc_en, 1'b1)
    $display("trim test done");
  endtask

  task automatic t_div();
    `WAIT_FOR(fixed_clk_en[0], 100)
    `CHK(fixed_clk_en[1], 1'b0)
    tick(1);
    `CHK({plb_clk_en, fixed_clk_en[11:1]}, 15'h7fff)
    `WAIT_FOR(fixed_clk_en[0], 100)
    `CHK(n + 1, (RATIO + 1) * P_MAIN)
    $display("divider test done");
  endtask

  task automatic t_switch();
    src_sel_t sel [4];
    int       per [4];
    int       n0;
    sel = '{SRC_LOWPOWER, SRC_CRYSTAL, SRC_EXTERNAL, SRC_MAIN};
    per = '{P_LOW, P_XTAL, P_EXT, P_MAIN};
    for (int i = 0; i < 4; i++)
    begin
      clk_sel = sel[i];
      tick(1);
      `CHK(switch_busy, 1'b1)
      `WAIT_FOR(!switch_busy, 500)
      `CHK(switch_busy, 1'b0)
      `WAIT_FOR(!root_fast_clock, 100)
      `WAIT_FOR(root_fast_clock, 100)
      `WAIT_FOR(!root_fast_clock, 100)
      n0 = n;
      `WAIT_FOR(root_fast_clock, 100)
      `CHK(n0 + n, per[i])
    end
    $display("switch test done");
  endtask

  task automatic t_wdt();
    lf_sel = LF_SEL_LOWPOWER;
    wdt_cfg = '{1'b1, 1'b0, 16'(TMO)};
    for (int k = 0; k < 8; k++)
    begin
      pulse(wdt_service);
      tick(P_LOW * TMO / 2);
    end
    `CHK(wdt_irq, 1'b0)
    deep_sleep = 1'b1;
    pulse(wdt_service);
    tick(P_LOW * TMO - 5);
    `CHK(wdt_irq, 1'b0)
    `WAIT_FOR(wdt_irq, 2 * P_LOW)
    `CHK(wdt_irq, 1'b1)
    deep_sleep = 1'b0;
    wdt_cfg.enable = 1'b0;
    tick(1);
    pulse(wdt_irq_clr);
    `CHK(wdt_irq, 1'b0)
    $display("watchdog irq test done");
  endtask

  task automatic t_wdt_reset();
    wdt_cfg = '{1'b1, 1'b1, 16'h0001};
    pulse(wdt_service);
    `WAIT_FOR(!core_rst_b, 4 * P_LOW)
    wdt_cfg.enable = 1'b0;
    `CHK(core_rst_b, 1'b0)
    `WAIT_FOR(core_rst_b, 10)
    `CHK(reset_cause, 3'h1)
    `CHK(main_osc_trim, TRIM_RESET)
    cause_clr = 3'h1;
    tick(1);
    cause_clr = 3'h0;
    `CHK(reset_cause, 3'h0)
    $display("watchdog reset test done");
  endtask

  task automatic t_sources();
    pulse(sw_reset_req);
    `WAIT_FOR(!core_rst_b, 4)
    `CHK(core_rst_b, 1'b0)
    `WAIT_FOR(core_rst_b, 10)
    `CHK(reset_cause, 3'h2)
    external_reset_pin_b = 1'b0;
    #1;
    `CHK(core_rst_b, 1'b0)
    tick(4);
    external_reset_pin_b = 1'b1;
    tick(1);
    `CHK(core_rst_b, 1'b0)
    `WAIT_FOR(core_rst_b, 10)
    `CHK(reset_cause, 3'h6)
    $display("reset source test done");
  endtask

  task automatic t_cal();
    lf_sel = LF_SEL_CRYSTAL;
    cal_req = '{1'b1, 16'h0002};
    tick(1);
    cal_req.start = 1'b0;
    `WAIT_FOR(cal_done, 4 * P_XTAL)
    `CHK(cal_done, 1'b1)
    // Window opens at start, so its first crystal period is partial
    `CHK(n > P_XTAL && n <= 2 * P_XTAL + 4, 1'b1)
    `CHK(cal_count >= 16'((n - 4) / P_MAIN) && cal_count <= 16'((n + 4) / P_MAIN), 1'b1)
    $display("calibration test done");
  endtask

  initial
  begin
    tick(1);
    t_reset();
    t_trim();
    t_div();
    t_switch();
    t_wdt();
    t_wdt_reset();
    t_sources();
    t_cal();
    t_reset();
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
endmodule // clock_watchdog_reset_unit_bench
